/* design/usa_core.sv */
// Purpose: serial port with baud generator, async transmit/receive and sync slave transmit
// Assumes: I_CORE_CLK is the oscillator, APB slave with no wait states
// Notes:   pins are split into input, output and active-low output enable
//
// Functional notes
// [RL1] baud is osc over 64, 16 or 4 times divisor+1
// [RL2] frame: start, eight or nine data, stop
// [RL3] least significant bit first, shared format
// [RL4] sync bit clear selects asynchronous operation
// [RL5] asynchronous activity halts during sleep
// [RL6] shifter reloads only after stop bit, one cycle
// [RL7] buffer-empty flag set by hardware, cleared by write
// [RL8] shifter-empty status bit is read only
// [RL9] send needs enable, data and shift clock
// [RL10] clearing transmit enable aborts and releases pin
// [RL11] nine-bit mode; ninth bit written before data
// [RL12] continuous receive enable starts async reception
// [RL13] receive line oversampled sixteen times per bit
// [RL14] stop bit moves word to buffer, sets ready
// [RL15] receive buffer is a two-entry fifo
// [RL16] overrun on full fifo, blocks further transfers
// [RL17] overrun cleared by toggling continuous receive enable
// [RL18] framing error and ninth bit stored per entry
// [RL19] software reads status before reading buffer
// [RL20] clock source clear selects external shift clock
// [RL21] queued second word waits, flag sets on move
// [RL22] software follows slave transmit setup order
// [RL23] divisor write restarts the baud generator
// [RL24] three samples per bit, majority vote
// [RL25] speed select ignored in synchronous mode
// [RL26] start on falling edge, sample bit centre
// [RL27] transmit pin idles high between characters
`timescale 1ns/100ps
module usa_core (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	input  wire logic        I_SLEEP,
	input  wire logic        I_TXCK_IN,
	output logic             O_TXCK_OUT,
	output logic             O_TXCK_OE_N,
	input  wire logic        I_RXDT_IN,
	output logic             O_RXDT_OUT,
	output logic             O_RXDT_OE_N,
	output logic             O_WAKE,
	output logic             O_IRQ
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              pready;
		logic              pslverr;
		logic [31:0]       prdata;
		logic [7:0]        int_ctl;
		logic [7:0]        per_en;
		logic [7:0]        rx_stat;
		logic [7:0]        tx_stat;
		logic [7:0]        baud;
		logic [7:0]        tx_buf;
		logic              tx_full;
		logic              tx_flag;
		logic              tx_en_d;
		usa_pkg::usa_tx_t  tx_st;
		logic [10:0]       transmit_shifter;
		logic [3:0]        tx_cnt;
		logic [3:0]        tx_os;
		logic [7:0]        brg_cnt;
		logic [1:0]        brg_ph;
		logic              os_tick;
		logic              ck_s1;
		logic              ck_s2;
		logic              ck_s3;
		logic              dt_s1;
		logic              dt_s2;
		usa_pkg::usa_rx_t  rx_st;
		logic [3:0]        rx_os;
		logic [3:0]        rx_cnt;
		logic [2:0]        smp;
		logic [8:0]        receive_shifter;
		logic              rx_prev;
		logic [1:0][9:0]   fifo;
		logic [1:0]        f_cnt;
		logic              f_rd;
		logic              overrun_error;
		logic              wake;
		logic              irq;
		logic              txck_o;
		logic              txck_oe_n;
		logic              dt_o;
		logic              dt_oe_n;
	} usa_state_t;

	usa_state_t q;
	usa_state_t nxt_q;
	logic [7:0] a_idx;
	logic       a_hit;
	logic       a_setup;
	logic       a_wr;
	logic       a_rd;
	logic       ld;
	logic       push;

	// majority of three samples
	function automatic logic usa_maj(input logic [2:0] s);
		usa_maj = (s[0] & s[1]) | (s[1] & s[2]) | (s[0] & s[2]);
	endfunction

	// index is mapped when it names one of the eight registers
	function automatic logic usa_mapped(input logic [7:0] i);
		usa_mapped = (i == usa_pkg::IDX_INT_CTL) || (i == usa_pkg::IDX_PER_FLAG) ||
			(i == usa_pkg::IDX_RX_STAT) || (i == usa_pkg::IDX_TX_BUF) ||
			(i == usa_pkg::IDX_RX_BUF) || (i == usa_pkg::IDX_PER_EN) ||
			(i == usa_pkg::IDX_TX_STAT) || (i == usa_pkg::IDX_BAUD);
	endfunction

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	// writes and pops happen only at the completing access edge
	assign a_idx   = I_PADDR[9:2];
	assign a_hit   = (I_PADDR[1:0] == 2'h0) && (I_PADDR[11:10] == 2'h0) && usa_mapped(a_idx);
	assign a_setup = I_PSEL && !I_PENABLE;
	assign a_wr    = I_PSEL && I_PENABLE && q.pready && I_PWRITE && a_hit;
	assign a_rd    = I_PSEL && I_PENABLE && q.pready && !I_PWRITE && a_hit;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       sync;
		logic       slave;
		logic       halt;
		logic       run;
		logic       ren;
		logic       tick;
		logic       base;
		logic       adv;
		logic       last;
		logic       txd;
		logic       bitv;
		logic       ck_fall;
		logic [7:0] rdv;
		logic [9:0] entry;
		logic [3:0] nbits;
		sync    = q.tx_stat[usa_pkg::TS_SYNC];
		slave   = sync && !q.tx_stat[usa_pkg::TS_CLK_SRC];
		halt    = I_SLEEP && !slave;
		run     = q.rx_stat[usa_pkg::RS_PORT_EN] && q.tx_stat[usa_pkg::TS_TX_EN];
		ren     = q.rx_stat[usa_pkg::RS_PORT_EN] && q.rx_stat[usa_pkg::RS_CONT_EN] && !sync;
		tick    = q.os_tick;
		base    = 1'b0;
		adv     = 1'b0;
		bitv    = 1'b0;
		last    = 1'b0;
		txd     = 1'b1;
		ck_fall = q.ck_s3 && !q.ck_s2;
		rdv     = 8'h00;
		ld      = 1'b0;
		push    = 1'b0;
		nbits   = q.rx_stat[usa_pkg::RS_NINE] ? usa_pkg::RX_DATA_9 : usa_pkg::RX_DATA_8;
		entry   = 10'h000;
		nxt_q   = q;

		// read mux, captured in the setup cycle so prdata is a flop
		if (a_idx == usa_pkg::IDX_INT_CTL) begin
			rdv = q.int_ctl;
		end else if (a_idx == usa_pkg::IDX_PER_FLAG) begin
			rdv[usa_pkg::PF_RX_READY] = (q.f_cnt != 2'h0);
			rdv[usa_pkg::PF_TX_EMPTY] = q.tx_flag;
		end else if (a_idx == usa_pkg::IDX_RX_STAT) begin
			rdv = q.rx_stat;
			rdv[usa_pkg::RS_FRAME_ERR] = (q.f_cnt != 2'h0) && q.fifo[q.f_rd][9]; // RL18
			rdv[usa_pkg::RS_OVERRUN]   = q.overrun_error;
			rdv[usa_pkg::RS_NINTH]     = (q.f_cnt != 2'h0) && q.fifo[q.f_rd][8];
		end else if (a_idx == usa_pkg::IDX_TX_BUF) begin
			rdv = q.tx_buf;
		end else if (a_idx == usa_pkg::IDX_RX_BUF) begin
			rdv = q.fifo[q.f_rd][7:0];
		end else if (a_idx == usa_pkg::IDX_PER_EN) begin
			rdv = q.per_en;
		end else if (a_idx == usa_pkg::IDX_TX_STAT) begin
			rdv = q.tx_stat;
			rdv[usa_pkg::TS_SH_EMPTY] = (q.tx_st == usa_pkg::TX_IDLE); // RL8
		end else if (a_idx == usa_pkg::IDX_BAUD) begin
			rdv = q.baud;
		end
		nxt_q.pready  = a_setup;
		nxt_q.pslverr = a_setup && !a_hit;
		nxt_q.prdata  = (a_setup && !I_PWRITE && a_hit) ? {24'h000000, rdv} : 32'h00000000;

		// register writes; status bits are never stored from the bus
		if (a_wr) begin
			if (a_idx == usa_pkg::IDX_INT_CTL) begin
				nxt_q.int_ctl = I_PWDATA[7:0];
			end else if (a_idx == usa_pkg::IDX_RX_STAT) begin
				nxt_q.rx_stat = {I_PWDATA[7:3], 3'h0};
			end else if (a_idx == usa_pkg::IDX_TX_BUF) begin
				nxt_q.tx_buf = I_PWDATA[7:0];
			end else if (a_idx == usa_pkg::IDX_PER_EN) begin
				nxt_q.per_en = I_PWDATA[7:0];
			end else if (a_idx == usa_pkg::IDX_TX_STAT) begin
				nxt_q.tx_stat = {I_PWDATA[7:4], 1'b0, I_PWDATA[2], 1'b0, I_PWDATA[0]};
			end else if (a_idx == usa_pkg::IDX_BAUD) begin
				nxt_q.baud = I_PWDATA[7:0];
			end
		end

		// baud generator: divisor write restarts it at once
		if (a_wr && a_idx == usa_pkg::IDX_BAUD) begin
			nxt_q.brg_cnt = 8'h00; // RL23
			nxt_q.brg_ph  = 2'h0;
		end else if (q.brg_cnt == q.baud) begin
			nxt_q.brg_cnt = 8'h00;
			nxt_q.brg_ph  = q.brg_ph + 2'h1;
			base          = 1'b1;
		end else begin
			nxt_q.brg_cnt = q.brg_cnt + 8'h01;
		end
		// high speed skips the divide by four, but only when asynchronous
		nxt_q.os_tick = base && ((q.tx_stat[usa_pkg::TS_HIGH_SPD] && !sync) || // RL1 RL25
			q.brg_ph == usa_pkg::BRG_LAST_PHASE);

		// pin synchronisers
		nxt_q.ck_s1 = I_TXCK_IN;
		nxt_q.ck_s2 = q.ck_s1;
		nxt_q.ck_s3 = q.ck_s2;
		nxt_q.dt_s1 = I_RXDT_IN;
		nxt_q.dt_s2 = q.dt_s1;

		// transmit shifter advance: 16 ticks per async bit, one tick per sync master bit, one clock fall per slave bit
		case (q.tx_st)
			usa_pkg::TX_SHIFT: begin
				if (!halt) begin // RL5
					if (!sync) begin
						if (tick) begin
							nxt_q.tx_os = q.tx_os + 4'h1;
							adv         = (q.tx_os == usa_pkg::OS_LAST);
						end
					end else if (slave) begin
						adv = ck_fall; // RL20
					end else begin
						adv = tick;
					end
				end
			end
			default: begin
				adv = 1'b0;
			end
		endcase
		last = adv && (q.tx_cnt == 4'h0);
		if (adv) begin
			nxt_q.transmit_shifter    = {1'b1, q.transmit_shifter[10:1]}; // RL3
			nxt_q.tx_cnt = q.tx_cnt - 4'h1;
		end
		if (last) begin
			nxt_q.tx_st = usa_pkg::TX_IDLE; // RL6
		end

		// reload straight after the stop bit, or from idle on a tick, at once in slave mode
		ld = q.tx_full && run && !halt && (last || (q.tx_st == usa_pkg::TX_IDLE && (slave || tick))); // RL9 RL21
		if (ld) begin
			nxt_q.tx_st = usa_pkg::TX_SHIFT;
			nxt_q.tx_os = 4'h0;
			// ninth bit is taken at transfer time, so it must be written first
			if (sync) begin
				nxt_q.transmit_shifter    = {2'h3, q.tx_stat[usa_pkg::TS_NINE] ? q.tx_stat[usa_pkg::TS_NINTH] : 1'b1, q.tx_buf};
				nxt_q.tx_cnt = q.tx_stat[usa_pkg::TS_NINE] ? usa_pkg::TX_BITS_S9 : usa_pkg::TX_BITS_S8;
			end else begin
				nxt_q.transmit_shifter    = {1'b1, q.tx_stat[usa_pkg::TS_NINE] ? q.tx_stat[usa_pkg::TS_NINTH] : 1'b1, // RL11
					q.tx_buf, 1'b0}; // RL2
				nxt_q.tx_cnt = q.tx_stat[usa_pkg::TS_NINE] ? usa_pkg::TX_BITS_A9 : usa_pkg::TX_BITS_A8;
			end
		end
		if (!run) begin
			nxt_q.tx_st = usa_pkg::TX_IDLE; // RL10
			nxt_q.transmit_shifter   = 11'h7FF;
			nxt_q.tx_os = 4'h0;
		end

		// buffer flag: set on transfer or enable rise, write clears, set wins
		nxt_q.tx_en_d = q.tx_stat[usa_pkg::TS_TX_EN];
		nxt_q.tx_full = (q.tx_full && !ld) || (a_wr && a_idx == usa_pkg::IDX_TX_BUF);
		if (ld || (q.tx_stat[usa_pkg::TS_TX_EN] && !q.tx_en_d)) begin
			nxt_q.tx_flag = 1'b1; // RL7
		end else if (a_wr && a_idx == usa_pkg::IDX_TX_BUF) begin
			nxt_q.tx_flag = 1'b0;
		end

		// pins: async uses the clock pin for data; sync puts data on the data pin
		txd = (q.tx_st == usa_pkg::TX_SHIFT) ? q.transmit_shifter[0] : 1'b1; // RL27
		if (!sync) begin // RL4
			nxt_q.txck_o    = txd;
			nxt_q.txck_oe_n = !run;
			nxt_q.dt_o      = 1'b1;
			nxt_q.dt_oe_n   = 1'b1;
		end else begin
			nxt_q.txck_o    = q.brg_ph[1];
			nxt_q.txck_oe_n = !(q.rx_stat[usa_pkg::RS_PORT_EN] && q.tx_stat[usa_pkg::TS_CLK_SRC]);
			nxt_q.dt_o      = txd;
			nxt_q.dt_oe_n   = !run;
		end

		// fifo pop on a receive buffer read
		if (a_rd && a_idx == usa_pkg::IDX_RX_BUF && q.f_cnt != 2'h0) begin
			nxt_q.f_rd  = !q.f_rd; // RL15
			nxt_q.f_cnt = q.f_cnt - 2'h1;
		end

		// receiver: three centre samples per bit, majority decides
		if (!ren) begin
			nxt_q.rx_st   = usa_pkg::RX_IDLE;
			nxt_q.overrun_error    = 1'b0; // RL17
			nxt_q.rx_prev = 1'b1;
		end else if (!halt && tick) begin // RL12 RL13
			case (q.rx_st)
				usa_pkg::RX_IDLE: begin
					nxt_q.rx_prev = q.dt_s2;
					if (q.rx_prev && !q.dt_s2) begin
						nxt_q.rx_st  = usa_pkg::RX_BITS; // RL26
						nxt_q.rx_os  = 4'h1;
						nxt_q.rx_cnt = 4'h0;
					end
				end
				default: begin
					nxt_q.rx_os = q.rx_os + 4'h1;
					if (q.rx_os >= usa_pkg::OS_SAMPLE_A && q.rx_os <= usa_pkg::OS_SAMPLE_C) begin
						nxt_q.smp = {q.smp[1:0], q.dt_s2}; // RL24
					end
					if (q.rx_os == usa_pkg::OS_DECIDE) begin
						bitv = usa_maj(q.smp);
						if (q.rx_cnt == 4'h0) begin
							if (bitv) begin
								nxt_q.rx_st   = usa_pkg::RX_IDLE;
								nxt_q.rx_prev = q.dt_s2;
							end
						end else if (q.rx_cnt <= nbits) begin
							nxt_q.receive_shifter = {bitv, q.receive_shifter[8:1]}; // RL3
						end else begin
							push          = 1'b1; // RL14
							nxt_q.rx_st   = usa_pkg::RX_IDLE;
							nxt_q.rx_prev = q.dt_s2;
						end
					end
					if (q.rx_os == usa_pkg::OS_LAST) begin
						nxt_q.rx_cnt = q.rx_cnt + 4'h1;
					end
				end
			endcase
		end

		// push with framing error and ninth bit beside the data
		entry = q.rx_stat[usa_pkg::RS_NINE] ? {!bitv, q.receive_shifter} : {!bitv, 1'b0, q.receive_shifter[8:1]}; // RL18
		if (push && !q.overrun_error) begin // RL16
			if (nxt_q.f_cnt == usa_pkg::FIFO_FULL) begin
				nxt_q.overrun_error = 1'b1;
			end else begin
				nxt_q.fifo[nxt_q.f_rd ^ nxt_q.f_cnt[0]] = entry;
				nxt_q.f_cnt = nxt_q.f_cnt + 2'h1;
			end
		end

		// wake request and gated interrupt
		nxt_q.wake = (q.tx_flag && q.per_en[usa_pkg::PF_TX_EMPTY]) ||
			((q.f_cnt != 2'h0) && q.per_en[usa_pkg::PF_RX_READY]);
		nxt_q.irq = nxt_q.wake && q.int_ctl[usa_pkg::IC_GLOBAL_EN] && q.int_ctl[usa_pkg::IC_PERIPH_EN]; // RL21
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge I_CORE_CLK) begin
		if (I_RST) begin
			q           <= '0;
			q.int_ctl   <= usa_pkg::RST_OTHER;
			q.tx_stat   <= usa_pkg::RST_TX_STAT;
			q.transmit_shifter       <= 11'h7FF;
			q.rx_prev   <= 1'b1;
			q.txck_o    <= 1'b1;
			q.txck_oe_n <= 1'b1;
			q.dt_o      <= 1'b1;
			q.dt_oe_n   <= 1'b1;
		end else begin
			q <= nxt_q;
		end
	end

	assign O_PRDATA    = q.prdata;
	assign O_PREADY    = q.pready;
	assign O_PSLVERR   = q.pslverr;
	assign O_TXCK_OUT  = q.txck_o;
	assign O_TXCK_OE_N = q.txck_oe_n;
	assign O_RXDT_OUT  = q.dt_o;
	assign O_RXDT_OE_N = q.dt_oe_n;
	assign O_WAKE      = q.wake;
	assign O_IRQ       = q.irq;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (I_RST);

	sequence s_tx_load;
		ld && !q.tx_stat[usa_pkg::TS_SYNC];
	endsequence
	sequence s_start_bit;
		(q.tx_st == usa_pkg::TX_SHIFT) ##1 !O_TXCK_OUT;
	endsequence

	brg_restart_a: assert property (a_wr && a_idx == usa_pkg::IDX_BAUD |=> q.brg_cnt == 8'h00 && q.brg_ph == 2'h0) // RL23
		else $error("baud generator not restarted by divisor write");
	txflag_clear_a: assert property (a_wr && a_idx == usa_pkg::IDX_TX_BUF && !ld |=> !q.tx_flag) // RL7
		else $error("buffer-empty flag not cleared by buffer write");
	tx_load_a: assert property (ld |=> q.tx_flag && q.tx_st == usa_pkg::TX_SHIFT) // RL6
		else $error("transfer to shifter did not set flag");
	start_bit_a: assert property (s_tx_load |=> s_start_bit) // RL2
		else $error("start bit not driven low after load");
	abort_a: assert property ($fell(q.tx_stat[usa_pkg::TS_TX_EN]) && !q.tx_stat[usa_pkg::TS_SYNC] |->
		##1 (O_TXCK_OE_N && q.tx_st == usa_pkg::TX_IDLE)) // RL10
		else $error("transmit not aborted on enable clear");
	sleep_halt_a: assert property (I_SLEEP && !q.tx_stat[usa_pkg::TS_SYNC] && q.tx_stat[usa_pkg::TS_TX_EN] &&
		q.rx_stat[usa_pkg::RS_PORT_EN] |=> $stable(q.transmit_shifter) && $stable(q.rx_os)) // RL5
		else $error("asynchronous activity during sleep");
	ovr_block_a: assert property (q.overrun_error |=> q.f_cnt <= $past(q.f_cnt)) // RL16
		else $error("fifo filled while overrun set");
	ovr_clear_a: assert property (!q.rx_stat[usa_pkg::RS_CONT_EN] |=> !q.overrun_error) // RL17
		else $error("overrun not cleared by receive reset");
	rx_push_a: assert property (push && !q.overrun_error && q.f_cnt == 2'h0 |=> q.f_cnt == 2'h1) // RL14
		else $error("received word not moved to fifo");
	apb_ready_a: assert property (a_setup |=> O_PREADY ##1 (!O_PREADY || a_setup)) // RL9
		else $error("apb answer timing wrong");

endmodule

/* shared/usa_pkg.sv */
// Purpose: shared constants and types of the serial port block
// Assumes: register index is the printed offset, byte address is index times four
// Notes:   bit positions are plain ints, reset values are sized to their registers
package usa_pkg;

	// ----------------------------------------------------------------
	// register indices (byte address = index * 4)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_INT_CTL  = 8'h0B;
	localparam logic [7:0] IDX_PER_FLAG = 8'h0C;
	localparam logic [7:0] IDX_RX_STAT  = 8'h18;
	localparam logic [7:0] IDX_TX_BUF   = 8'h19;
	localparam logic [7:0] IDX_RX_BUF   = 8'h1A;
	localparam logic [7:0] IDX_PER_EN   = 8'h8C;
	localparam logic [7:0] IDX_TX_STAT  = 8'h98;
	localparam logic [7:0] IDX_BAUD     = 8'h99;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int TS_CLK_SRC   = 7;
	localparam int TS_NINE      = 6;
	localparam int TS_TX_EN     = 5;
	localparam int TS_SYNC      = 4;
	localparam int TS_HIGH_SPD  = 2;
	localparam int TS_SH_EMPTY  = 1;
	localparam int TS_NINTH     = 0;
	localparam int RS_PORT_EN   = 7;
	localparam int RS_NINE      = 6;
	localparam int RS_CONT_EN   = 4;
	localparam int RS_FRAME_ERR = 2;
	localparam int RS_OVERRUN   = 1;
	localparam int RS_NINTH     = 0;
	localparam int PF_RX_READY  = 5;
	localparam int PF_TX_EMPTY  = 4;
	localparam int IC_GLOBAL_EN = 7;
	localparam int IC_PERIPH_EN = 6;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_TX_STAT = 8'h02;
	localparam logic [7:0] RST_OTHER   = 8'h00;

	// ----------------------------------------------------------------
	// timing: base tick every divisor+1 clocks, four base ticks per
	// slow oversample tick, sixteen oversample ticks per async bit
	// ----------------------------------------------------------------
	localparam logic [1:0] BRG_LAST_PHASE = 2'h3;
	localparam logic [3:0] OS_LAST        = 4'hF;
	localparam logic [3:0] OS_SAMPLE_A    = 4'h7;
	localparam logic [3:0] OS_SAMPLE_C    = 4'h9;
	localparam logic [3:0] OS_DECIDE      = 4'hA;
	localparam logic [3:0] TX_BITS_A8     = 4'h9;
	localparam logic [3:0] TX_BITS_A9     = 4'hA;
	localparam logic [3:0] TX_BITS_S8     = 4'h7;
	localparam logic [3:0] TX_BITS_S9     = 4'h8;
	localparam logic [3:0] RX_DATA_8      = 4'h8;
	localparam logic [3:0] RX_DATA_9      = 4'h9;
	localparam logic [1:0] FIFO_FULL      = 2'h2;

	typedef enum logic {TX_IDLE, TX_SHIFT} usa_tx_t;
	typedef enum logic {RX_IDLE, RX_BITS} usa_rx_t;

endpackage

/* test/usa_far_end.sv */
// Purpose: remote serial partner of the serial port block
// Assumes: idle-high line, bit time in clocks set by the bench
// Notes:   receiver samples mid-bit; sender always returns the line high; shift clock idles low
`timescale 1ns/100ps
module usa_far_end (
	input  wire logic i_clk,
	input  wire logic i_line,
	input  wire logic i_dat,
	output logic      o_line,
	output logic      o_ck
);
	int bit_clks = 16;
	initial o_line = 1'b1;
	initial o_ck = 1'b0;
	// whole frame: start, data lsb first, chosen stop level, one idle bit
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		o_line <= 1'b0;
		repeat (bit_clks) @(posedge i_clk);
		for (int i = 0; i < n; i++) begin
			o_line <= d[i];
			repeat (bit_clks) @(posedge i_clk);
		end
		o_line <= stop;
		repeat (bit_clks) @(posedge i_clk);
		o_line <= 1'b1;
		repeat (bit_clks) @(posedge i_clk);
	endtask
	// waits bounded for a start bit, then samples each bit at its centre
	task automatic get(input int n, output logic [8:0] d, output logic ok);
		int w;
		w = 0;
		d = 9'h000;
		while (i_line !== 1'b0 && w < 20000) begin
			@(posedge i_clk);
			w++;
		end
		repeat (bit_clks / 2) @(posedge i_clk);
		ok = (i_line === 1'b0);
		for (int i = 0; i < n; i++) begin
			repeat (bit_clks) @(posedge i_clk);
			d[i] = i_line;
		end
		repeat (bit_clks) @(posedge i_clk);
		ok = ok & (i_line === 1'b1);
	endtask
	// slave clock master: bit taken at the rise, the device moves on after the fall
	task automatic clk_in(input int n, output logic [8:0] d);
		d = 9'h000;
		for (int i = 0; i < n; i++) begin
			repeat (8) @(posedge i_clk);
			o_ck <= 1'b1;
			d[i] = i_dat;
			repeat (8) @(posedge i_clk);
			o_ck <= 1'b0;
		end
	endtask
endmodule

/* test/usart_async_and_sync_slave_test.sv */
// Purpose: self-checking bench of the serial port block
// Assumes: released pins show what the partner drives on them
// Notes:   one task per scenario; bit time 16 clocks unless a scenario changes it
`timescale 1ns/100ps
module usart_async_and_sync_slave_test;
	logic        clk, rst, psel, penable, pwrite, sleep;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, txck_out, txck_oe_n, rxdt_out, rxdt_oe_n;
	logic        wake, irq, far_line, far_ck, txck_pin, rxdt_pin;
	int          errors, tests_run;
	// pin levels: a released clock pin carries the partner's shift clock
	assign txck_pin = txck_oe_n ? far_ck : txck_out;
	assign rxdt_pin = rxdt_oe_n ? far_line : rxdt_out;
	usa_core dut (.I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_SLEEP(sleep), .I_TXCK_IN(txck_pin), .O_TXCK_OUT(txck_out), .O_TXCK_OE_N(txck_oe_n),
		.I_RXDT_IN(rxdt_pin), .O_RXDT_OUT(rxdt_out), .O_RXDT_OE_N(rxdt_oe_n), .O_WAKE(wake), .O_IRQ(irq));
	usa_far_end far (.i_clk(clk), .i_line(txck_pin), .i_dat(rxdt_pin), .o_line(far_line), .o_ck(far_ck));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ----------------------------------------------------------------
	// bus and compare helpers
	// ----------------------------------------------------------------
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd,
		output logic err);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		// no answer time assumed: only the watchdog ends a hung wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		logic       e;
		apb(1'b1, idx, d, r, e);
	endtask
	task automatic rchk(input string n, input logic [7:0] idx, input logic [7:0] x);
		logic [7:0] r;
		logic       e;
		apb(1'b0, idx, 8'h00, r, e);
		chk(n, {1'b0, x}, {1'b0, r});
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] r;
		logic       e;
		rchk("tx_status", usa_pkg::IDX_TX_STAT, 8'h02);
		rchk("baud", usa_pkg::IDX_BAUD, 8'h00);
		rchk("rx_status", usa_pkg::IDX_RX_STAT, 8'h00);
		apb(1'b0, 8'h01, 8'h00, r, e);
		chk("slverr", 9'h001, {8'h00, e});
	endtask
	// second word waits in the buffer, so the empty flag drops meanwhile
	task automatic t_tx();
		logic [8:0] d;
		logic       ok;
		wr(usa_pkg::IDX_BAUD, 8'h00);
		wr(usa_pkg::IDX_RX_STAT, 8'h80);
		wr(usa_pkg::IDX_TX_STAT, 8'h24);
		@(posedge clk);
		chk("idle_pin", 9'h001, {7'h00, txck_oe_n, txck_out});
		rchk("flags", usa_pkg::IDX_PER_FLAG, 8'h10);
		fork
			begin
				far.get(8, d, ok);
				chk("word0", 9'h0A5, d);
				far.get(8, d, ok);
				chk("word1", 9'h03C, d);
				chk("frame", 9'h001, {8'h00, ok});
			end
			begin
				wr(usa_pkg::IDX_TX_BUF, 8'hA5);
				wr(usa_pkg::IDX_TX_BUF, 8'h3C);
				rchk("flags", usa_pkg::IDX_PER_FLAG, 8'h00);
			end
		join
		repeat (16) @(posedge clk);
		rchk("tx_status", usa_pkg::IDX_TX_STAT, 8'h26);
		wr(usa_pkg::IDX_PER_EN, 8'h10);
		wr(usa_pkg::IDX_INT_CTL, 8'hC0);
		@(posedge clk);
		chk("wake_irq", 9'h003, {7'h00, wake, irq});
		wr(usa_pkg::IDX_PER_EN, 8'h00);
	endtask
	task automatic t_nine();
		logic [8:0] d;
		logic       ok;
		wr(usa_pkg::IDX_TX_STAT, 8'h65);
		fork
			far.get(9, d, ok);
			wr(usa_pkg::IDX_TX_BUF, 8'h5A);
		join
		chk("nine_bit", 9'h15A, d);
		wr(usa_pkg::IDX_TX_STAT, 8'h24);
	endtask
	// slow speed at divisor 0 and fast speed at divisor 2
	task automatic t_rate();
		logic [8:0] d;
		logic       ok;
		for (int k = 0; k < 2; k++) begin
			far.bit_clks = k ? 48 : 64;
			wr(usa_pkg::IDX_BAUD, k ? 8'h02 : 8'h00);
			wr(usa_pkg::IDX_TX_STAT, k ? 8'h24 : 8'h20);
			fork
				far.get(8, d, ok);
				wr(usa_pkg::IDX_TX_BUF, 8'hC3);
			join
			chk("rate_word", 9'h0C3, d);
		end
		far.bit_clks = 16;
		wr(usa_pkg::IDX_BAUD, 8'h00);
		wr(usa_pkg::IDX_TX_STAT, 8'h24);
	endtask
	task automatic t_rx();
		wr(usa_pkg::IDX_RX_STAT, 8'h90);
		far.send(9'h03C, 8, 1'b1);
		rchk("flags", usa_pkg::IDX_PER_FLAG, 8'h30);
		rchk("rx_status", usa_pkg::IDX_RX_STAT, 8'h90);
		rchk("rx_buf", usa_pkg::IDX_RX_BUF, 8'h3C);
		rchk("flags", usa_pkg::IDX_PER_FLAG, 8'h10);
		far.send(9'h081, 8, 1'b0);
		rchk("rx_status", usa_pkg::IDX_RX_STAT, 8'h94);
		rchk("rx_buf", usa_pkg::IDX_RX_BUF, 8'h81);
		far.send(9'h011, 8, 1'b1);
		far.send(9'h022, 8, 1'b1);
		far.send(9'h033, 8, 1'b1);
		rchk("rx_status", usa_pkg::IDX_RX_STAT, 8'h92);
		rchk("rx_buf", usa_pkg::IDX_RX_BUF, 8'h11);
		rchk("rx_buf", usa_pkg::IDX_RX_BUF, 8'h22);
		far.send(9'h044, 8, 1'b1);
		rchk("flags", usa_pkg::IDX_PER_FLAG, 8'h10);
		wr(usa_pkg::IDX_RX_STAT, 8'h80);
		wr(usa_pkg::IDX_RX_STAT, 8'h90);
		rchk("rx_status", usa_pkg::IDX_RX_STAT, 8'h90);
		sleep <= 1'b1;
		far.send(9'h055, 8, 1'b1);
		rchk("flags", usa_pkg::IDX_PER_FLAG, 8'h10);
		sleep <= 1'b0;
	endtask
	task automatic t_abort();
		wr(usa_pkg::IDX_TX_BUF, 8'h77);
		repeat (40) @(posedge clk);
		wr(usa_pkg::IDX_TX_STAT, 8'h04);
		repeat (2) @(posedge clk);
		chk("pin_release", 9'h001, {8'h00, txck_oe_n});
	endtask
	// slave transmit in sleep: second queued word waits, its move sets the flag
	task automatic t_slave();
		logic [8:0] d;
		wr(usa_pkg::IDX_RX_STAT, 8'h80);
		wr(usa_pkg::IDX_TX_STAT, 8'h30);
		wr(usa_pkg::IDX_PER_EN, 8'h10);
		sleep <= 1'b1;
		wr(usa_pkg::IDX_TX_BUF, 8'hA1);
		wr(usa_pkg::IDX_TX_BUF, 8'h5E);
		rchk("flags", usa_pkg::IDX_PER_FLAG, 8'h00);
		chk("wake_irq", 9'h000, {7'h00, wake, irq});
		far.clk_in(8, d);
		chk("slave0", 9'h0A1, d);
		repeat (4) @(posedge clk);
		rchk("flags", usa_pkg::IDX_PER_FLAG, 8'h10);
		chk("wake_irq", 9'h003, {7'h00, wake, irq});
		far.clk_in(8, d);
		chk("slave1", 9'h05E, d);
		sleep <= 1'b0;
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		sleep = 1'b0;
		errors = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_tx();
		t_nine();
		t_rate();
		t_rx();
		t_abort();
		t_slave();
		summarize();
	end
	// whole run is some 3.3k cycles; 50k means a hang
	initial begin
		#500000;
		errors++;
		summarize();
	end
endmodule
